// *** hdl/usbe_flags.sv ***
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// - id pin change sets flag bit 7
// - millisecond timer expiry sets flag bit 6
// - line settled 1 ms and new sets bit 5
// - wake activity sets flag bit 4
// - supply below session end sets bit 3
// - session end input change sets bit 2
// - session valid change sets bit 0; bit 1 absent
// - bits 31..8 read zero, writes ignored
// - write one clears flag, zero keeps it
// - device mode: token crc failure sets error bit 1
// - host mode: busy at frame countdown zero sets bit 1
// - packet id check failure sets error bit 0
// - late grant or truncation sets memory error
// - over 16 idle bit times sets turnaround error
// - one enable bit per error flag
// - enable bit 1 gates crc or frame end
// - summary enable gates errors to module flag
// - status head: endpoint, direction, odd bank fields
// - four-entry status queue, clearing done flag advances
module usbe_flags #(
  parameter int MS_CYCLES = usbe_pkg::MS_CYCLES_DEF
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [usbe_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                 wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [31:0]                 rd_data,
  output logic                             module_irq_flag,
  input  wire logic                        id_pin,
  input  wire logic [1:0]                  line_state,
  input  wire logic                        wake_activity,
  input  wire logic                        session_end_in,
  input  wire logic                        session_valid_in,
  input  wire logic                        token_crc_fail,
  input  wire logic                        sof_count_zero,
  input  wire logic                        link_busy,
  input  wire logic                        pid_check_fail,
  input  wire logic                        bit_stuff_fail,
  input  wire logic                        bus_matrix_fail,
  input  wire logic                        mem_grant_late,
  input  wire logic                        rx_truncated,
  input  wire logic                        field_size_fail,
  input  wire logic                        data_crc_fail,
  input  wire logic                        eop_seen,
  input  wire logic                        bit_tick,
  input  wire logic                        response_seen,
  input  wire logic                        xfer_push,
  input  wire logic [3:0]                  xfer_ep,
  input  wire logic                        xfer_dir_tx,
  input  wire logic                        xfer_odd
);
  import usbe_pkg::*;

  localparam logic [MS_CNT_W-1:0]   MS_LAST   = MS_CNT_W'(MS_CYCLES - 1);
  localparam logic [TURN_CNT_W-1:0] TURN_TRIP = TURN_CNT_W'(TURN_LIMIT_BITS + 1);

  typedef struct packed {
    logic [7:0]            otg_flags;
    logic [7:0]            err_flags;
    logic [7:0]            err_en;
    logic                  sum_en;
    logic                  host_mode;
    logic                  primed;
    logic                  id_prev;
    logic                  sess_end_prev;
    logic                  sess_valid_prev;
    logic [1:0]            line_last;
    logic [1:0]            line_settled;
    logic [MS_CNT_W-1:0]   line_cnt;
    logic [MS_CNT_W-1:0]   ms_cnt;
    usbe_ta_t              ta_state;
    logic [TURN_CNT_W-1:0] ta_cnt;
    logic [31:0]           rd_data;
    logic                  irq;
  } usbe_flags_st_t;

  usbe_flags_st_t              st_reg;
  usbe_flags_st_t              st_next;
  logic [7:0]                  err_hit;
  logic                        err_summary;
  logic [STAT_ENTRY_W-1:0]     stat_head;
  logic                        stat_valid;
  logic                        stat_pop;
  logic [STAT_ENTRY_W-1:0]     stat_entry;
  logic [7:0]                  otg_set;
  logic [7:0]                  err_set;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    addr_hit = (a == t);
  endfunction : addr_hit

  // ---------------------------------------------------------------
  // transfer status queue
  // ---------------------------------------------------------------
  assign stat_entry = {xfer_ep, xfer_dir_tx, xfer_odd};
  assign stat_pop   = wr_en && addr_hit(addr, ADDR_XFER_DONE) && wr_data[DONE_FLAG_BIT];

  usbe_stat_fifo u_stat_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .push      (xfer_push),
    .push_data (stat_entry),
    .pop       (stat_pop),
    .head      (stat_head),
    .not_empty (stat_valid),
    .full      ()
  );

  // ---------------------------------------------------------------
  // error summary
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_hit
    assign err_hit[i] = st_reg.err_flags[i] & st_reg.err_en[i];
  end
  assign err_summary = |err_hit;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    otg_set = 8'h00;
    err_set = 8'h00;

    // edges only after one sample, so reset values never look like a change
    st_next.primed          = 1'b1;
    st_next.id_prev         = id_pin;
    st_next.sess_end_prev   = session_end_in;
    st_next.sess_valid_prev = session_valid_in;
    if (st_reg.primed) begin
      otg_set[OTG_ID_BIT]        = (id_pin != st_reg.id_prev);
      otg_set[OTG_SESS_DROP_BIT] = session_end_in && !st_reg.sess_end_prev;
      otg_set[OTG_SESS_END_BIT]  = (session_end_in != st_reg.sess_end_prev);
      otg_set[OTG_SUPPLY_BIT]    = (session_valid_in != st_reg.sess_valid_prev);
    end
    otg_set[OTG_WAKE_BIT] = wake_activity;

    // free-running millisecond timer
    if (st_reg.ms_cnt >= MS_LAST) begin
      st_next.ms_cnt      = '0;
      otg_set[OTG_MS_BIT] = 1'b1;
    end else begin
      st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
    end

    // line settle watch; the count saturates so one settle gives one flag
    st_next.line_last = line_state;
    if (line_state != st_reg.line_last) begin
      st_next.line_cnt = '0;
    end else if (st_reg.line_cnt < MS_LAST) begin
      st_next.line_cnt = st_reg.line_cnt + 1'b1;
    end else if (st_reg.line_last != st_reg.line_settled) begin
      st_next.line_settled  = st_reg.line_last;
      otg_set[OTG_LINE_BIT] = 1'b1;
    end

    // turnaround watch, counted in bit times after end of packet
    case (st_reg.ta_state)
      USBE_TA_IDLE: begin
        if (eop_seen) begin
          st_next.ta_state = USBE_TA_WAIT;
          st_next.ta_cnt   = '0;
        end
      end
      USBE_TA_WAIT: begin
        if (response_seen) begin
          st_next.ta_state = USBE_TA_IDLE;
        end else if (st_reg.ta_cnt == TURN_TRIP) begin
          err_set[ERR_TURN_BIT] = 1'b1;
          st_next.ta_state      = USBE_TA_IDLE;
        end else if (bit_tick) begin
          st_next.ta_cnt = st_reg.ta_cnt + 1'b1;
        end
      end
      default: begin
        st_next.ta_state = USBE_TA_IDLE;
      end
    endcase

    err_set[ERR_STUFF_BIT]  = bit_stuff_fail;
    err_set[ERR_MATRIX_BIT] = bus_matrix_fail;
    err_set[ERR_DMA_BIT]    = mem_grant_late || rx_truncated;
    err_set[ERR_FIELD_BIT]  = field_size_fail;
    err_set[ERR_DCRC_BIT]   = data_crc_fail;
    err_set[ERR_PID_BIT]    = pid_check_fail;
    if (st_reg.host_mode) begin
      err_set[ERR_TOKEN_EOF_BIT] = sof_count_zero && link_busy;
    end else begin
      err_set[ERR_TOKEN_EOF_BIT] = token_crc_fail;
    end

    // register writes; only the low byte is stored anywhere
    if (wr_en) begin
      if (addr_hit(addr, ADDR_OTG_EVENT)) begin
        st_next.otg_flags = st_reg.otg_flags & ~wr_data[7:0];
      end
      if (addr_hit(addr, ADDR_ERR_FLAGS)) begin
        st_next.err_flags = st_reg.err_flags & ~wr_data[7:0];
      end
      if (addr_hit(addr, ADDR_ERR_EN)) begin
        st_next.err_en = wr_data[7:0];
      end
      if (addr_hit(addr, ADDR_MAIN_IRQ_EN)) begin
        st_next.sum_en = wr_data[MAIN_SUM_EN_BIT];
      end
      if (addr_hit(addr, ADDR_MODE_CTRL)) begin
        st_next.host_mode = wr_data[MODE_HOST_BIT];
      end
    end
    // a set in the clearing cycle wins
    st_next.otg_flags = (st_next.otg_flags | otg_set) & OTG_IMPL_MASK;
    st_next.err_flags = st_next.err_flags | err_set;

    // read data, one cycle after the strobe only
    st_next.rd_data = 32'h0;
    if (rd_en) begin
      if (addr_hit(addr, ADDR_OTG_EVENT)) begin
        st_next.rd_data[7:0] = st_reg.otg_flags;
      end
      if (addr_hit(addr, ADDR_ERR_FLAGS)) begin
        st_next.rd_data[7:0] = st_reg.err_flags;
      end
      if (addr_hit(addr, ADDR_ERR_EN)) begin
        st_next.rd_data[7:0] = st_reg.err_en;
      end
      if (addr_hit(addr, ADDR_XFER_STAT)) begin
        // head is meaningless while the done flag is low, so show zero
        st_next.rd_data[7:0] = stat_valid ? {stat_head, 2'h0} : 8'h00;
      end
      if (addr_hit(addr, ADDR_MAIN_IRQ_EN)) begin
        st_next.rd_data[MAIN_SUM_EN_BIT] = st_reg.sum_en;
      end
      if (addr_hit(addr, ADDR_XFER_DONE)) begin
        st_next.rd_data[DONE_FLAG_BIT] = stat_valid;
        st_next.rd_data[DONE_IRQ_BIT]  = st_reg.irq;
      end
      if (addr_hit(addr, ADDR_MODE_CTRL)) begin
        st_next.rd_data[MODE_HOST_BIT] = st_reg.host_mode;
      end
    end

    st_next.irq = err_summary && st_reg.sum_en;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg              <= '0;
      st_reg.otg_flags    <= FLAGS_RESET;
      st_reg.err_flags    <= FLAGS_RESET;
      st_reg.err_en       <= ERR_EN_RESET;
      st_reg.line_last    <= LINE_RESET;
      st_reg.line_settled <= LINE_RESET;
      st_reg.ta_state     <= USBE_TA_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rd_data         = st_reg.rd_data;
  assign module_irq_flag = st_reg.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  id_change_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.primed && id_pin != st_reg.id_prev) |=> st_reg.otg_flags[OTG_ID_BIT])
    else $error("id change did not set flag");

  ms_timer_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.ms_cnt == MS_LAST) |=> st_reg.otg_flags[OTG_MS_BIT])
    else $error("timer expiry did not set flag");

  line_settle_time_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st_reg.otg_flags[OTG_LINE_BIT]) |-> ($past(st_reg.line_cnt) == MS_LAST))
    else $error("line flag set before settle time");

  upper_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rd_en) |-> (rd_data[31:8] == 24'h0))
    else $error("upper read bits not zero");

  err_w1c_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr_en && addr == ADDR_ERR_FLAGS && wr_data[ERR_PID_BIT] && !pid_check_fail)
      |=> !st_reg.err_flags[ERR_PID_BIT])
    else $error("write one did not clear flag");

  token_crc_dev_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !st_reg.host_mode && token_crc_fail) |=> st_reg.err_flags[ERR_TOKEN_EOF_BIT])
    else $error("token crc error not flagged");

  frame_end_host_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.host_mode && sof_count_zero && link_busy)
      |=> st_reg.err_flags[ERR_TOKEN_EOF_BIT])
    else $error("frame end error not flagged");

  pid_fail_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && pid_check_fail) |=> st_reg.err_flags[ERR_PID_BIT])
    else $error("pid failure not flagged");

  turn_trip_count_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(st_reg.err_flags[ERR_TURN_BIT]) |-> ($past(st_reg.ta_cnt) == TURN_TRIP))
    else $error("turnaround error at wrong count");

  irq_gated_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !st_reg.sum_en) |=> !module_irq_flag)
    else $error("irq raised with summary disabled");

  irq_summary_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.sum_en && |(st_reg.err_flags & st_reg.err_en)) |=> module_irq_flag)
    else $error("enabled error did not raise irq");

  wake_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wake_activity) |=> st_reg.otg_flags[OTG_WAKE_BIT])
    else $error("wake activity did not set flag");

  sess_drop_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.primed && session_end_in && !st_reg.sess_end_prev)
      |=> st_reg.otg_flags[OTG_SESS_DROP_BIT])
    else $error("session drop did not set flag");

  sess_end_chg_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.primed && session_end_in != st_reg.sess_end_prev)
      |=> st_reg.otg_flags[OTG_SESS_END_BIT])
    else $error("session end change did not set flag");

  supply_chg_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && st_reg.primed && session_valid_in != st_reg.sess_valid_prev)
      |=> st_reg.otg_flags[OTG_SUPPLY_BIT])
    else $error("session valid change did not set flag");

  mem_err_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && (mem_grant_late || rx_truncated)) |=> st_reg.err_flags[ERR_DMA_BIT])
    else $error("memory error not flagged");

  err_en_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && wr_en && addr == ADDR_ERR_EN) |=> (st_reg.err_en == $past(wr_data[7:0])))
    else $error("enable write not stored");

  read_idle_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && !rd_en) |=> (rd_data == 32'h0))
    else $error("read data not idle");

  stat_empty_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && rd_en && addr == ADDR_XFER_STAT && !stat_valid) |=> (rd_data == 32'h0))
    else $error("empty status head not zero");

endmodule : usbe_flags

// *** hdl/usbe_pkg.sv ***
package usbe_pkg;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  ADDR_OTG_EVENT   = 8'h00;
  localparam logic [7:0]  ADDR_ERR_FLAGS   = 8'h04;
  localparam logic [7:0]  ADDR_ERR_EN      = 8'h08;
  localparam logic [7:0]  ADDR_XFER_STAT   = 8'h0C;
  localparam logic [7:0]  ADDR_MAIN_IRQ_EN = 8'h10;
  localparam logic [7:0]  ADDR_XFER_DONE   = 8'h14;
  localparam logic [7:0]  ADDR_MODE_CTRL   = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OTG_ID_BIT         = 7;
  localparam int OTG_MS_BIT         = 6;
  localparam int OTG_LINE_BIT       = 5;
  localparam int OTG_WAKE_BIT       = 4;
  localparam int OTG_SESS_DROP_BIT  = 3;
  localparam int OTG_SESS_END_BIT   = 2;
  localparam int OTG_SUPPLY_BIT     = 0;
  localparam logic [7:0] OTG_IMPL_MASK = 8'hFD;

  localparam int ERR_STUFF_BIT      = 7;
  localparam int ERR_MATRIX_BIT     = 6;
  localparam int ERR_DMA_BIT        = 5;
  localparam int ERR_TURN_BIT       = 4;
  localparam int ERR_FIELD_BIT      = 3;
  localparam int ERR_DCRC_BIT       = 2;
  localparam int ERR_TOKEN_EOF_BIT  = 1;
  localparam int ERR_PID_BIT        = 0;

  localparam int MAIN_SUM_EN_BIT    = 1;
  localparam int DONE_FLAG_BIT      = 0;
  localparam int DONE_IRQ_BIT       = 1;
  localparam int MODE_HOST_BIT      = 0;

  localparam int STAT_EP_LSB        = 4;
  localparam int STAT_DIR_BIT       = 3;
  localparam int STAT_ODD_BIT       = 2;
  localparam int STAT_ENTRY_W       = 6;
  localparam int STAT_DEPTH         = 4;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] ERR_EN_RESET  = 8'h00;
  localparam logic [1:0] LINE_RESET    = 2'h0;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_TIME_NS      = 1000000;
  localparam int MS_CYCLES_DEF   = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CNT_W        = 17;
  localparam int TURN_LIMIT_BITS = 16;
  localparam int TURN_CNT_W      = 5;

  typedef enum logic [1:0] {
    USBE_TA_IDLE = 2'h1,
    USBE_TA_WAIT = 2'h2
  } usbe_ta_t;

endpackage : usbe_pkg

// *** hdl/usbe_stat_fifo.sv ***
`timescale 1ns/10ps
module usbe_stat_fifo (
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic                              ce,
  input  wire logic                              push,
  input  wire logic [usbe_pkg::STAT_ENTRY_W-1:0] push_data,
  input  wire logic                              pop,
  output logic      [usbe_pkg::STAT_ENTRY_W-1:0] head,
  output logic                                   not_empty,
  output logic                                   full
);
  import usbe_pkg::*;

  typedef struct packed {
    logic [STAT_DEPTH-1:0][STAT_ENTRY_W-1:0] mem;
    logic [1:0]                              wr_ptr;
    logic [1:0]                              rd_ptr;
    logic [2:0]                              count;
  } usbe_fifo_st_t;

  usbe_fifo_st_t st_reg;
  usbe_fifo_st_t st_next;
  logic          do_push;
  logic          do_pop;

  assign head      = st_reg.mem[st_reg.rd_ptr];
  assign not_empty = (st_reg.count != 3'h0);
  assign full      = (st_reg.count == 3'(STAT_DEPTH));

  // push into a full queue is dropped; the oldest entries are kept
  always_comb begin
    st_next = st_reg;
    do_push = push && !full;
    do_pop  = pop && not_empty;
    if (do_push) begin
      st_next.mem[st_reg.wr_ptr] = push_data;
      st_next.wr_ptr             = st_reg.wr_ptr + 2'h1;
    end
    if (do_pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 2'h1;
    end
    st_next.count = st_reg.count + {2'h0, do_push} - {2'h0, do_pop};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  queue_advance_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ce && pop && not_empty && !push) |=> (st_reg.count == $past(st_reg.count) - 3'h1))
    else $error("queue did not advance on pop");

endmodule : usbe_stat_fifo

// *** verif/usb_otg_error_event_flags_tb.sv ***
`timescale 1ns/10ps
module usb_otg_error_event_flags_tb;
  import usbe_pkg::*;
  localparam int MSC = 20;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        ce = 1'b1;
  logic [10:0] err_src = 11'h000;
  logic        xfer_push = 1'b0;
  logic [5:0]  xfer_v = 6'h00;
  wire  [31:0] rd_data;
  wire         module_irq_flag;
  wire         id_pin, wake_activity, session_end_in, session_valid_in;
  wire         eop_seen, bit_tick, response_seen;
  wire  [1:0]  line_state;
  int          failures = 0;
  int          checks = 0;
  logic        rd_taken = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [5:0]  ent[5];
  logic [7:0]  en, set;
  logic        sum;

  always #5 clk_sys = ~clk_sys;

  usbe_far_end_model p (.clk_sys(clk_sys), .id_pin(id_pin), .line_state(line_state),
    .wake_activity(wake_activity), .session_end_in(session_end_in),
    .session_valid_in(session_valid_in), .eop_seen(eop_seen), .bit_tick(bit_tick),
    .response_seen(response_seen));

  usbe_flags #(.MS_CYCLES(MSC)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .module_irq_flag(module_irq_flag), .id_pin(id_pin), .line_state(line_state),
    .wake_activity(wake_activity), .session_end_in(session_end_in),
    .session_valid_in(session_valid_in), .token_crc_fail(err_src[1]),
    .sof_count_zero(err_src[9]), .link_busy(err_src[10]), .pid_check_fail(err_src[0]),
    .bit_stuff_fail(err_src[7]), .bus_matrix_fail(err_src[6]),
    .mem_grant_late(err_src[5]), .rx_truncated(err_src[8]),
    .field_size_fail(err_src[3]), .data_crc_fail(err_src[2]), .eop_seen(eop_seen),
    .bit_tick(bit_tick), .response_seen(response_seen), .xfer_push(xfer_push),
    .xfer_ep(xfer_v[5:2]), .xfer_dir_tx(xfer_v[1]), .xfer_odd(xfer_v[0]));

  // ---------------------------------------------------------------
  // bus master and stimulus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask : rd

  // read, clear by writing ones, confirm clear; ms timer bit left out
  task automatic otg(input logic [31:0] e);
    rd(ADDR_OTG_EVENT, e, 32'hFFFF_FFBF);
    wr(ADDR_OTG_EVENT, e);
    rd(ADDR_OTG_EVENT, 32'h0, 32'hFFFF_FFBF);
  endtask : otg

  task automatic pulse(input logic [10:0] v);
    @(posedge clk_sys);
    err_src <= v;
    @(posedge clk_sys);
    err_src <= 11'h000;
  endtask : pulse

  task automatic push(input logic [5:0] v);
    @(posedge clk_sys);
    xfer_v <= v;
    xfer_push <= 1'b1;
    @(posedge clk_sys);
    xfer_push <= 1'b0;
  endtask : push

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // monitor: read data only in the cycle after the strobe
  // ---------------------------------------------------------------
  always @(posedge clk_sys) rd_taken <= rd_en;

  always @(negedge clk_sys) begin
    logic [31:0] e, m;
    if (rd_taken) begin
      checks++;
      e = exp_q.size() ? exp_q.pop_front() : 32'hX;
      m = msk_q.size() ? msk_q.pop_front() : 32'hFFFF_FFFF;
      if ((rd_data & m) !== (e & m)) begin
        failures++;
        $display("wrong value at %0t: read got %h expected %h", $time, rd_data, e);
      end
    end else if (!rst && rd_data !== 32'h0) begin
      failures++;
      $display("wrong value at %0t: read data not idle", $time);
    end
  end

  initial begin
    #100000;
    failures++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(38459));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_OTG_EVENT, 32'h0, 32'hFFFF_FFBF);
    rd(ADDR_ERR_FLAGS, 32'h0);
    rd(ADDR_ERR_EN, 32'h0);
    rd(ADDR_XFER_STAT, 32'h0);
    rd(8'h1C, 32'h0);
    repeat (MSC) @(posedge clk_sys);
    rd(ADDR_OTG_EVENT, 32'h40, 32'h40);
    wr(ADDR_OTG_EVENT, 32'hFFFF_FFFF);
    p.toggle_id();
    otg(32'h80);
    p.set_supply(1'b1, 1'b0);
    otg(32'h0C);
    p.set_supply(1'b0, 1'b0);
    otg(32'h04);
    p.set_supply(1'b0, 1'b1);
    otg(32'h01);
    p.wake();
    otg(32'h10);
    p.set_line(2'h1);
    repeat (MSC + 5) @(posedge clk_sys);
    otg(32'h20);
    p.set_line(2'h2);
    repeat (MSC / 2) @(posedge clk_sys);
    p.set_line(2'h1);
    repeat (MSC + 5) @(posedge clk_sys);
    otg(32'h00);
    for (int k = 0; k < 9; k++) begin
      if (k != 4) begin
        pulse(11'h1 << k);
        rd(ADDR_ERR_FLAGS, 32'h1 << ((k == 8) ? 5 : k));
        wr(ADDR_ERR_FLAGS, 32'h0);
        rd(ADDR_ERR_FLAGS, 32'h1 << ((k == 8) ? 5 : k));
        wr(ADDR_ERR_FLAGS, 32'h1 << ((k == 8) ? 5 : k));
        rd(ADDR_ERR_FLAGS, 32'h0);
      end
    end
    pulse(11'h600);
    rd(ADDR_ERR_FLAGS, 32'h0);
    wr(ADDR_MODE_CTRL, 32'h1);
    pulse(11'h002);
    pulse(11'h200);
    rd(ADDR_ERR_FLAGS, 32'h0);
    pulse(11'h600);
    rd(ADDR_ERR_FLAGS, 32'h2);
    wr(ADDR_ERR_FLAGS, 32'hFF);
    wr(ADDR_MODE_CTRL, 32'h0);
    p.turnaround(16, 1'b1);
    rd(ADDR_ERR_FLAGS, 32'h0);
    p.turnaround(17, 1'b0);
    rd(ADDR_ERR_FLAGS, 32'h10);
    wr(ADDR_ERR_FLAGS, 32'hFF);
    // a frozen block must ignore an error pulse
    ce <= 1'b0;
    pulse(11'h001);
    ce <= 1'b1;
    rd(ADDR_ERR_FLAGS, 32'h0);
    wr(ADDR_ERR_FLAGS, 32'hFF);
    for (int i = 0; i < 10; i++) begin
      en = $urandom;
      set = $urandom & 8'hEF;
      sum = $urandom;
      if (i == 0) begin
        en = 8'h02;
        set = 8'h02;
        sum = 1'b1;
      end
      wr(ADDR_ERR_EN, {24'hFFFFFF, en});
      rd(ADDR_ERR_EN, {24'h0, en});
      wr(ADDR_MAIN_IRQ_EN, {30'h0, sum, 1'b0});
      pulse({3'h0, set});
      rd(ADDR_ERR_FLAGS, {24'h0, set});
      rd(ADDR_XFER_DONE, {30'h0, sum & (|(set & en)), 1'b0});
      @(negedge clk_sys);
      checks++;
      if (module_irq_flag !== (sum & (|(set & en)))) begin
        failures++;
        $display("wrong value at %0t: irq pin mismatch", $time);
      end
      wr(ADDR_ERR_FLAGS, 32'hFF);
    end
    for (int i = 0; i < 5; i++) begin
      ent[i] = $urandom;
      push(ent[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_XFER_DONE, 32'h1, 32'h1);
      rd(ADDR_XFER_STAT, {24'h0, ent[i], 2'h0});
      wr(ADDR_XFER_DONE, 32'h1);
    end
    rd(ADDR_XFER_DONE, 32'h0, 32'h1);
    rd(ADDR_XFER_STAT, 32'h0);
    repeat (3) @(posedge clk_sys);
    stop_test();
  end
endmodule : usb_otg_error_event_flags_tb

// *** verif/usbe_far_end_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// bus-side partner: pins, line state and turnaround timing
// ---------------------------------------------------------------
module usbe_far_end_model (
  input  wire logic       clk_sys,
  output logic            id_pin,
  output logic      [1:0] line_state,
  output logic            wake_activity,
  output logic            session_end_in,
  output logic            session_valid_in,
  output logic            eop_seen,
  output logic            bit_tick,
  output logic            response_seen
);
  initial begin
    id_pin = 1'b0;
    line_state = 2'h0;
    wake_activity = 1'b0;
    session_end_in = 1'b0;
    session_valid_in = 1'b0;
    eop_seen = 1'b0;
    bit_tick = 1'b0;
    response_seen = 1'b0;
  end

  task automatic toggle_id();
    @(posedge clk_sys);
    id_pin <= ~id_pin;
  endtask : toggle_id

  task automatic set_supply(input logic sess_end, input logic sess_valid);
    @(posedge clk_sys);
    session_end_in <= sess_end;
    session_valid_in <= sess_valid;
  endtask : set_supply

  task automatic set_line(input logic [1:0] v);
    @(posedge clk_sys);
    line_state <= v;
  endtask : set_line

  task automatic wake();
    @(posedge clk_sys);
    wake_activity <= 1'b1;
    @(posedge clk_sys);
    wake_activity <= 1'b0;
  endtask : wake

  // ticks only inside the watch; a reply is optional so a silent peer can be shown
  task automatic turnaround(input int ticks, input logic reply);
    @(posedge clk_sys);
    eop_seen <= 1'b1;
    @(posedge clk_sys);
    eop_seen <= 1'b0;
    repeat (ticks) begin
      @(posedge clk_sys);
      bit_tick <= 1'b1;
      @(posedge clk_sys);
      bit_tick <= 1'b0;
    end
    if (reply) begin
      @(posedge clk_sys);
      response_seen <= 1'b1;
      @(posedge clk_sys);
      response_seen <= 1'b0;
    end
  endtask : turnaround
endmodule : usbe_far_end_model
